//--- include/lsod_pkg.sv
package lsod_pkg;

  // ==========================================================
  // Opcode range bases and masks
  localparam logic [15:0] LSOD_MASK_6 = 16'hFFC0;
  localparam logic [15:0] LSOD_MASK_5 = 16'hFFE0;
  localparam logic [15:0] LSOD_MASK_7 = 16'hFF80;
  localparam logic [15:0] LSOD_MASK_10 = 16'hFC00;
  localparam logic [15:0] LSOD_HLD_PI_Z = 16'h9400;
  localparam logic [15:0] LSOD_HLD_PI_X = 16'h9440;
  localparam logic [15:0] LSOD_HLD_PD_Z = 16'h9480;
  localparam logic [15:0] LSOD_HLD_PD_X = 16'h94C0;
  localparam logic [15:0] LSOD_HLD_PN_Z = 16'h9500;
  localparam logic [15:0] LSOD_HLD_PN_X = 16'h9540;
  localparam logic [15:0] LSOD_HST_PI = 16'h9600;
  localparam logic [15:0] LSOD_HST_PD = 16'h9680;
  localparam logic [15:0] LSOD_HST_PN = 16'h9700;
  localparam logic [15:0] LSOD_BLD_PI_Z = 16'h9800;
  localparam logic [15:0] LSOD_BLD_PI_X = 16'h9840;
  localparam logic [15:0] LSOD_BLD_PD_Z = 16'h9880;
  localparam logic [15:0] LSOD_BLD_PD_X = 16'h98C0;
  localparam logic [15:0] LSOD_BLD_PN_Z = 16'h9900;
  localparam logic [15:0] LSOD_BLD_PN_X = 16'h9940;
  localparam logic [15:0] LSOD_BST_PI = 16'h9A00;
  localparam logic [15:0] LSOD_BST_PD = 16'h9A80;
  localparam logic [15:0] LSOD_BST_PN = 16'h9B00;
  // Index group: base of load/store, bits 7:5 select form
  localparam logic [15:0] LSOD_ILD_PI = 16'h9C00;
  localparam logic [15:0] LSOD_ILD_PD = 16'h9C80;
  localparam logic [15:0] LSOD_IST_PD = 16'h9E80;
  localparam logic [15:0] LSOD_ILD_PN = 16'h9D00;
  localparam logic [15:0] LSOD_IST_PI = 16'h9E00;
  localparam logic [15:0] LSOD_IST_PN = 16'h9F00;
  localparam logic [15:0] LSOD_ILD_MOD = 16'h9D80;
  localparam logic [15:0] LSOD_IST_MOD = 16'h9F80;
  localparam logic [15:0] LSOD_OLD_W = 16'hA000;
  localparam logic [15:0] LSOD_OLD_HZ = 16'hA400;
  localparam logic [15:0] LSOD_OLD_HX = 16'hA800;
  localparam logic [15:0] LSOD_OLD_P = 16'hAC00;
  localparam logic [15:0] LSOD_OST_W = 16'hB000;

  // ==========================================================
  // Field positions
  localparam int LSOD_REG_A_LSB = 0;
  localparam int LSOD_REG_B_LSB = 3;
  localparam int LSOD_OFS_LSB = 6;
  localparam int LSOD_IDX_LSB = 0;
  localparam int LSOD_IDATA_LSB = 2;
  localparam int LSOD_MOD_LSB = 5;
  localparam int LSOD_SUBFORM_LSB = 5;
  localparam logic [2:0] LSOD_SUB_DECR = 3'h4;

  // ==========================================================
  // Step sizes in bytes
  localparam logic [2:0] LSOD_STEP_BYTE = 3'h1;
  localparam logic [2:0] LSOD_STEP_HALF = 3'h2;
  localparam logic [2:0] LSOD_STEP_WORD = 3'h4;

  typedef enum logic [1:0] {LSOD_SZ_BYTE, LSOD_SZ_HALF, LSOD_SZ_WORD} lsod_size_e;
  typedef enum logic [1:0] {LSOD_AM_NONE, LSOD_AM_INC, LSOD_AM_DEC, LSOD_AM_MOD} lsod_amode_e;
  typedef enum logic [1:0] {LSOD_PART_FULL, LSOD_PART_LOW, LSOD_PART_HIGH} lsod_part_e;
  typedef enum logic [1:0] {LSOD_BASE_PTR, LSOD_BASE_IDX, LSOD_BASE_PTR_OFS} lsod_base_e;

  typedef struct packed {
    logic valid;
    logic is_load;
    logic sign_ext;
    logic dst_is_ptr;
    lsod_size_e size;
    lsod_amode_e amode;
    lsod_part_e part;
    lsod_base_e base;
    logic [2:0] addr_reg;
    logic [2:0] data_reg;
    logic [1:0] mod_reg;
    logic [6:0] offset;
    logic [2:0] step;
  } lsod_uop_s;

endpackage

//--- core/lsod_decoder.sv
`timescale 1ns/1ps
// Contract
// - 0x9400/0x9440: half load, post-increment pointer, Z/X
// - 0x9480/0x94C0: half load, post-decrement pointer, Z/X
// - 0x9500/0x9540: half load, unmodified pointer, Z/X
// - 0x9600/0x9680/0x9700: low-half store, inc/dec/none
// - 0x9800/0x9840: byte load, post-increment, Z/X
// - 0x9880/0x98C0: byte load, post-decrement, Z/X
// - 0x9900/0x9940: byte load, unmodified pointer, Z/X
// - 0x9A00/0x9A80/0x9B00: byte store, inc/dec/none
// - 0x9C00-0x9C5F: index load inc, full/low/high
// - 0x9C80-0x9CDF: index load dec, full/low/high
// - 0x9D00-0x9D5F: index load none, full/low/high
// - 0x9D80-0x9DFF: word load, index plus modifier
// - 0x9E00-0x9E5F: index store inc, full/low/high
// - 0x9E80-0x9EDF: index store dec, full/low/high
// - 0x9F00-0x9F5F: index store none, full/low/high
// - 0x9F80-0x9FFF: word store, index post-modified
// - 0xA000-0xA3FF: word load, pointer plus offset*4
// - 0xA400/0xA800: half load, pointer plus offset*2
// - 0xAC00-0xAFFF: pointer load, pointer plus offset*4
// - 0xB000-0xB3FF: word store, pointer plus offset*4
module lsod_decoder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // From fetch
  input wire logic i_valid,
  input wire logic [15:0] i_opcode,
  // To address generation and register file
  output lsod_pkg::lsod_uop_s o_uop
);
  import lsod_pkg::*;

  // ==========================================================
  // Range matches
  function automatic logic hit(input logic [15:0] op, input logic [15:0] mask, input logic [15:0] base);
    hit = (op & mask) == base;
  endfunction

  wire logic [15:0] op = i_opcode;
  wire logic [2:0] subform = op[LSOD_SUBFORM_LSB +: 3];
  // Subforms 3 and 7 of the index load/store blocks decode to no form
  wire logic sub_data = subform[1:0] != 2'h3;

  // ==========================================================
  // Pointer half-word loads

  wire logic hld_pi_z = hit(op, LSOD_MASK_6, LSOD_HLD_PI_Z);

  wire logic hld_pi_x = hit(op, LSOD_MASK_6, LSOD_HLD_PI_X);

  wire logic hld_pd_z = hit(op, LSOD_MASK_6, LSOD_HLD_PD_Z);

  wire logic hld_pd_x = hit(op, LSOD_MASK_6, LSOD_HLD_PD_X);

  wire logic hld_pn_z = hit(op, LSOD_MASK_6, LSOD_HLD_PN_Z);

  wire logic hld_pn_x = hit(op, LSOD_MASK_6, LSOD_HLD_PN_X);

  // Extension and step classes of the half loads
  wire logic hld_z = hld_pi_z | hld_pd_z | hld_pn_z;
  wire logic hld_x = hld_pi_x | hld_pd_x | hld_pn_x;
  wire logic hld_inc = hld_pi_z | hld_pi_x;
  wire logic hld_dec = hld_pd_z | hld_pd_x;

  // ==========================================================
  // Pointer low-half stores

  wire logic hst_inc = hit(op, LSOD_MASK_6, LSOD_HST_PI);

  wire logic hst_dec = hit(op, LSOD_MASK_6, LSOD_HST_PD);

  wire logic hst_pn = hit(op, LSOD_MASK_6, LSOD_HST_PN);

  // All low-half stores
  wire logic hst = hst_inc | hst_dec | hst_pn;

  // ==========================================================
  // Pointer byte loads

  wire logic bld_pi_z = hit(op, LSOD_MASK_6, LSOD_BLD_PI_Z);

  wire logic bld_pi_x = hit(op, LSOD_MASK_6, LSOD_BLD_PI_X);

  wire logic bld_pd_z = hit(op, LSOD_MASK_6, LSOD_BLD_PD_Z);

  wire logic bld_pd_x = hit(op, LSOD_MASK_6, LSOD_BLD_PD_X);

  wire logic bld_pn_z = hit(op, LSOD_MASK_6, LSOD_BLD_PN_Z);

  wire logic bld_pn_x = hit(op, LSOD_MASK_6, LSOD_BLD_PN_X);

  // Extension and step classes of the byte loads
  wire logic bld_z = bld_pi_z | bld_pd_z | bld_pn_z;
  wire logic bld_x = bld_pi_x | bld_pd_x | bld_pn_x;
  wire logic bld_inc = bld_pi_z | bld_pi_x;
  wire logic bld_dec = bld_pd_z | bld_pd_x;

  // ==========================================================
  // Pointer byte stores

  wire logic bst_inc = hit(op, LSOD_MASK_6, LSOD_BST_PI);

  wire logic bst_dec = hit(op, LSOD_MASK_6, LSOD_BST_PD);

  wire logic bst_pn = hit(op, LSOD_MASK_6, LSOD_BST_PN);

  // All byte stores
  wire logic bst = bst_inc | bst_dec | bst_pn;

  // ==========================================================
  // Index register loads

  wire logic ild_pi = hit(op, LSOD_MASK_7, LSOD_ILD_PI) & sub_data;

  wire logic ild_pd = hit(op, LSOD_MASK_7, LSOD_ILD_PD) & sub_data;

  wire logic ild_pn = hit(op, LSOD_MASK_7, LSOD_ILD_PN) & sub_data;

  // ==========================================================
  // Index register stores

  wire logic ist_pi = hit(op, LSOD_MASK_7, LSOD_IST_PI) & sub_data;

  wire logic ist_pd = hit(op, LSOD_MASK_7, LSOD_IST_PD) & sub_data;

  wire logic ist_pn = hit(op, LSOD_MASK_7, LSOD_IST_PN) & sub_data;

  // ==========================================================
  // Modifier register forms

  wire logic ild_mod = hit(op, LSOD_MASK_7, LSOD_ILD_MOD);

  wire logic ist_mod = hit(op, LSOD_MASK_7, LSOD_IST_MOD);

  // ==========================================================
  // Pointer plus scaled offset

  wire logic old_w = hit(op, LSOD_MASK_10, LSOD_OLD_W);

  wire logic old_hz = hit(op, LSOD_MASK_10, LSOD_OLD_HZ);

  wire logic old_hx = hit(op, LSOD_MASK_10, LSOD_OLD_HX);

  wire logic old_p = hit(op, LSOD_MASK_10, LSOD_OLD_P);

  wire logic ost_w = hit(op, LSOD_MASK_10, LSOD_OST_W);

  // ==========================================================
  // Form classes

  wire logic ptr_form = hld_z | hld_x | hst | bld_z | bld_x | bst;
  wire logic idx_form = ild_pi | ild_pd | ild_pn | ist_pi | ist_pd | ist_pn;
  wire logic ofs_form = old_w | old_hz | old_hx | old_p | ost_w;
  wire logic mod_form = ild_mod | ist_mod;
  // A covered opcode falls in exactly one class
  wire logic any_hit = ptr_form | idx_form | ofs_form | mod_form;

  // ==========================================================
  // Direction and access size

  // Every covered load range
  wire logic is_load = hld_z
    | hld_x
    | bld_z
    | bld_x
    | ild_pi
    | ild_pd
    | ild_pn
    | ild_mod
    | old_w
    | old_hz
    | old_hx
    | old_p;

  wire logic sign_ext = hld_x | bld_x | old_hx;

  // Byte forms are the pointer byte loads and stores only
  wire logic is_byte = bld_z | bld_x | bst;
  // Index subforms 1 and 2 move one half of the data register
  wire logic idx_half = idx_form & (subform[1:0] != 2'h0);
  wire logic is_half = hld_z
    | hld_x
    | hst
    | old_hz
    | old_hx
    | idx_half;
  // Word is whatever remains
  wire lsod_size_e size = is_byte ? LSOD_SZ_BYTE : (is_half ? LSOD_SZ_HALF : LSOD_SZ_WORD);

  // ==========================================================
  // Address mode and post-modify step

  // Step forms, pointer and index alike
  wire logic am_inc = hld_inc | hst_inc | bld_inc | bst_inc | ild_pi | ist_pi;
  wire logic am_dec = hld_dec | hst_dec | bld_dec | bst_dec | ild_pd | ist_pd;
  // Modifier forms never overlap the step forms
  wire lsod_amode_e amode = mod_form ? LSOD_AM_MOD
    : (am_inc ? LSOD_AM_INC : (am_dec ? LSOD_AM_DEC : LSOD_AM_NONE));
  wire logic step_on = am_inc | am_dec;
  wire logic [2:0] size_bytes = is_byte ? LSOD_STEP_BYTE : (is_half ? LSOD_STEP_HALF : LSOD_STEP_WORD);
  wire logic [2:0] step = step_on ? size_bytes : 3'h0;

  // ==========================================================
  // Register part and address base

  // Index subform 1 selects the low half, 2 the high half
  wire lsod_part_e idx_part = (subform[1:0] == 2'h1) ? LSOD_PART_LOW
    : ((subform[1:0] == 2'h2) ? LSOD_PART_HIGH : LSOD_PART_FULL);
  wire lsod_part_e ptr_part = hst ? LSOD_PART_LOW : LSOD_PART_FULL;
  wire lsod_part_e part = idx_form ? idx_part : ptr_part;
  wire logic idx_base = idx_form | mod_form;
  wire lsod_base_e base = ofs_form ? LSOD_BASE_PTR_OFS : (idx_base ? LSOD_BASE_IDX : LSOD_BASE_PTR);

  // ==========================================================
  // Register numbers

  // Index register numbers are two bits wide
  wire logic [2:0] idx_addr = {1'b0, op[LSOD_IDX_LSB +: 2]};
  wire logic [2:0] addr_reg = idx_base ? idx_addr : op[LSOD_REG_B_LSB +: 3];
  wire logic [2:0] data_reg = idx_base ? op[LSOD_IDATA_LSB +: 3] : op[LSOD_REG_A_LSB +: 3];
  wire logic [1:0] mod_reg = mod_form ? op[LSOD_MOD_LSB +: 2] : 2'h0;

  // ==========================================================
  // Byte offsets

  wire logic [3:0] word_scaled_offset_field = op[LSOD_OFS_LSB +: 4];
  wire logic [3:0] halfword_scaled_offset_field = op[LSOD_OFS_LSB +: 4];
  wire logic ofs_word = old_w | old_p | ost_w;
  wire logic ofs_half = old_hz | old_hx;
  wire logic [6:0] word_ofs = {1'b0, word_scaled_offset_field, 2'h0};
  wire logic [6:0] half_ofs = {2'h0, halfword_scaled_offset_field, 1'b0};
  wire logic [6:0] offset = ofs_word ? word_ofs : (ofs_half ? half_ofs : 7'h00);

  wire lsod_uop_s uop_next = '{
    valid: i_valid & any_hit,
    is_load: is_load,
    sign_ext: sign_ext,
    dst_is_ptr: old_p,
    size: size,
    amode: amode,
    part: part,
    base: base,
    addr_reg: addr_reg,
    data_reg: data_reg,
    mod_reg: mod_reg,
    offset: offset,
    step: step
  };

  // ==========================================================
  // Output register
  // One whole micro-op per clock, so the datapath never sees a mix
  lsod_uop_s uop_reg;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      uop_reg <= '0;
    end else begin
      uop_reg <= uop_next;
    end
  end
  assign o_uop = uop_reg;

endmodule

//--- tb/lsod_decoder_props.sv
`timescale 1ns/1ps
module lsod_decoder_props (
  // Watched decoder ports
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire logic [15:0] i_opcode,
  input wire lsod_pkg::lsod_uop_s o_uop
);
  import lsod_pkg::*;
  logic v_reg;
  logic [15:0] w_reg;
  // Opcode taken on the same edge as the micro-op it produced
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      v_reg <= 1'h0;
      w_reg <= 16'h0000;
    end else begin
      v_reg <= i_valid;
      w_reg <= i_opcode;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_HALF_PTR: assert property (v_reg && w_reg[15:9] == 7'h4A && w_reg[8:7] != 2'h3 |->
    o_uop.valid && o_uop.size == LSOD_SZ_HALF && o_uop.sign_ext == w_reg[6]) else $error("bad half load");
  AST_BYTE_STEP: assert property (v_reg && w_reg[15:8] == 8'h98 |->
    o_uop.step == 3'h1 && o_uop.amode == (w_reg[7] ? LSOD_AM_DEC : LSOD_AM_INC)) else $error("bad byte step");
  AST_PTR_STORE: assert property (v_reg && w_reg[15:8] inside {8'h96, 8'h9A} && !w_reg[6] |->
    !o_uop.is_load && o_uop.size == (w_reg[11] ? LSOD_SZ_BYTE : LSOD_SZ_HALF)) else $error("bad store");
  AST_IDX_PART: assert property (v_reg && w_reg[15:10] == 6'h27 && w_reg[8:7] != 2'h3 && w_reg[6:5] != 2'h3 |->
    o_uop.part == lsod_part_e'(w_reg[6:5]) && o_uop.is_load == !w_reg[9]) else $error("bad index part");
  AST_IDX_MOD: assert property (v_reg && w_reg[15:10] == 6'h27 && w_reg[8:7] == 2'h3 |->
    o_uop.amode == LSOD_AM_MOD && o_uop.mod_reg == w_reg[6:5]) else $error("bad modifier form");
  AST_WORD_OFS: assert property (v_reg && w_reg[15:10] inside {6'h28, 6'h2B, 6'h2C} |->
    o_uop.offset == {1'h0, w_reg[9:6], 2'h0} && o_uop.dst_is_ptr == (w_reg[15:10] == 6'h2B)) else $error("bad offset");
  AST_HALF_OFS: assert property (v_reg && w_reg[15:10] inside {6'h29, 6'h2A} |->
    o_uop.offset == {2'h0, w_reg[9:6], 1'h0} && o_uop.sign_ext == w_reg[11]) else $error("bad half offset");
  AST_REFUSE: assert property (!v_reg || w_reg[15:5] == 11'h4F3 |->
    !o_uop.valid) else $error("uncovered opcode accepted");
endmodule
bind lsod_decoder lsod_decoder_props i_props (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid),
  .i_opcode(i_opcode), .o_uop(o_uop));

//--- tb/lsod_fetch_model.sv
`timescale 1ns/1ps
module lsod_fetch_model (
  // Request from bench
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [15:0] i_word,
  // To decoder
  output logic [15:0] o_opcode
);
  logic [15:0] last_reg = 16'h0000;
  // Idle cycles show a toggling pattern, the last word inverted and then the last word again
  always_ff @(posedge i_clk) last_reg <= o_opcode;
  assign o_opcode = i_req ? i_word : ~last_reg;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lsod_pkg::*;
  logic i_clk = 1'h0, i_reset = 1'h1, req = 1'h0;
  logic [15:0] word = 16'h0000, f_opcode;
  lsod_uop_s uop;
  int n_mismatch = 0, cmp_count = 0;
  always #25 i_clk = ~i_clk;
  lsod_fetch_model i_fetch (.i_clk(i_clk), .i_req(req), .i_word(word), .o_opcode(f_opcode));
  lsod_decoder i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_valid(req), .i_opcode(f_opcode), .o_uop(uop));
  // Key: valid, load, sign, ptr dest, size, mode, base, offset, step; only valid when exp is all zero
  task automatic op(input logic r, input logic [15:0] w, input logic [19:0] exp);
    logic [19:0] got;
    req = r;
    word = w;
    @(posedge i_clk);
    #1;
    got = {uop.valid, uop.is_load, uop.sign_ext, uop.dst_is_ptr, uop.size, uop.amode, uop.base, uop.offset, uop.step};
    cmp_count++;
    if ((exp[19] ? got : {got[19], 19'h0}) !== exp) begin
      n_mismatch++;
      $display("[ERR] uop key for %h exp %h got %h", w, exp, got);
    end
  endtask
  // Key: part, address register, data register, modifier register
  task automatic regs(input logic [15:0] w, input logic [9:0] exp);
    logic [9:0] got;
    req = 1'h1;
    word = w;
    @(posedge i_clk);
    #1;
    got = {uop.part, uop.addr_reg, uop.data_reg, uop.mod_reg};
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] uop regs for %h exp %h got %h", w, exp, got);
    end
  endtask
  task automatic t_reg_fields();
    regs(16'h9441, 10'h004);
    regs(16'h9637, 10'h1DC);
    regs(16'h9C5A, 10'h258);
    regs(16'h9DFF, 10'h07F);
    regs(16'hAC2D, 10'h0B4);
    $display("t_reg_fields done");
  endtask
  task automatic t_ptr_forms();
    logic [35:0] tbl [8] = '{36'h9441E5002, 36'h94BFC6002, 36'h957FE4000, 36'h968086002,
      36'h9B3F80000, 36'h9840E1001, 36'h98BFC2001, 36'h9900C0000};
    foreach (tbl[i]) op(1'h1, tbl[i][35:20], tbl[i][19:0]);
    $display("t_ptr_forms done");
  endtask
  task automatic t_idx_ofs_forms();
    logic [35:0] tbl [13] = '{36'h9C1FC9404, 36'h9CA0C6402, 36'h9D40C4400, 36'h9DFFCB400, 36'h9E5F85402,
      36'h9E808A404, 36'h9F2084400, 36'h9F808B400, 36'hA3FFC89E0, 36'hA440C4810, 36'hABC0E48F0,
      36'hAC47D8820, 36'hB3C0889E0};
    foreach (tbl[i]) op(1'h1, tbl[i][35:20], tbl[i][19:0]);
    $display("t_idx_ofs_forms done");
  endtask
  task automatic t_refuse_reset();
    op(1'h1, 16'h9E60, 20'h00000);
    op(1'h0, 16'h9441, 20'h00000);
    i_reset = 1'h1;
    op(1'h1, 16'h9441, 20'h00000);
    i_reset = 1'h0;
    op(1'h1, 16'h9441, 20'hE5002);
    $display("t_refuse_reset done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_reset = 1'h0;
    t_ptr_forms();
    t_idx_ofs_forms();
    t_refuse_reset();
    t_reg_fields();
    tally_and_finish();
  end
endmodule
